// *** rtl/pss_pkg.sv ***
// Package of constants and types for the power state sequencer
// =====================================================================
// Notes on behaviour
// - Exactly one of Shutdown, Sleep or Active holds at all times.
// - Shutdown powers everything off; only factory record survives.
// - In Shutdown everything except regulator enable and crystal trim is ignored.
// - Sleep runs on slow oscillator; wakes on host activity or timer.
// - Sleep: pulse skip regulator, retention kept, host port on.
// - Active has transmit, receive and a short idle sub-state.
// - Active: high power regulator, analog, crystal, logic all on from the PLL step on.
// - Sleep and Active transitions happen without host control.
// - Enable low from host puts the block into Shutdown.
// - Enable rising leaves Shutdown into Active idle.
// - Before association, sleep once booted whenever no host activity or transmit/receive request pends.
// - After association, sleep only when power save allows.
// - Any host command forces wake; no host action lets it sleep.
// - Wake follows regulator, power, crystal, PLL, boot, base, RF.
// - Early wake steps equal; cold boot copies factory record.
// - Cold wake calibrates all channels; warm wake one channel.
// - Crystal stops in Sleep; slow oscillator runs wake timer.
// - Slow oscillator calibrated at runtime against system clock.
// - Wake interval measured from sleep entry, where the timer reloads.
// - Crystal trim from non-volatile memory corrects 20 ppm.
package pss_pkg;
  // ===================================================================
  // Timing
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned RC_HZ         = 32_000;
  localparam int unsigned CRYSTAL_HZ    = 40_000_000;
  // Slow oscillator tick period in system cycles
  localparam int unsigned RC_DIV        = CLK_HZ / RC_HZ;
  localparam logic [9:0]  RC_DIV_INIT   = 10'(RC_DIV - 1);
  // Step durations in cycles, less one
  localparam logic [7:0]  T_REG_CYC     = 8'h04;
  localparam logic [7:0]  T_PWR_CYC     = 8'h08;
  localparam logic [7:0]  T_CRYSTAL_CYC = 8'h20;
  localparam logic [7:0]  T_PLL_CYC     = 8'h10;
  localparam logic [7:0]  T_BOOT_CYC    = 8'h10;
  localparam logic [7:0]  T_BB_COLD_CYC = 8'h40;
  localparam logic [7:0]  T_BB_WARM_CYC = 8'h08;
  localparam logic [7:0]  T_RF_COLD_CYC = 8'h80;
  localparam logic [7:0]  T_RF_WARM_CYC = 8'h10;
  // Calibration window in slow ticks, less one, and trim limit
  localparam logic [7:0]  CAL_TICKS     = 8'h10;
  localparam int unsigned TRIM_PPM      = 20;
  localparam logic signed [7:0] TRIM_MAX = 8'(TRIM_PPM);
  localparam logic [23:0] CAL_RESET     = 24'h00_0000;
  // ===================================================================
  // States
  typedef enum logic [1:0] {PS_SHUTDOWN, PS_SLEEP, PS_ACTIVE} pss_pwr_t;
  typedef enum logic [1:0] {SUB_IDLE, SUB_TX, SUB_RX} pss_sub_t;
  typedef enum logic [3:0] {
    ST_OFF, ST_REG, ST_PWR, ST_CRYSTAL, ST_PLL, ST_BOOT, ST_BB, ST_RF,
    ST_RUN, ST_SLEEP
  } pss_seq_t;
  // ===================================================================
  // Power rail controls
  typedef struct packed {
    logic reg_on;
    logic pulse_skip_low_power;
    logic analog_on;
    logic crystal_osc_on;
    logic pll_on;
    logic logic_on;
    logic retention_on;
    logic host_if_on;
    logic rc_osc_on;
  } pss_rails_t;
  // Firmware view of the link
  typedef struct packed {
    logic     associated;
    logic     ps_allow;
    logic     host_pending;
    logic     tx_req;
    logic     rx_req;
  } pss_ctl_t;
endpackage

// *** rtl/pss_power_state_sequencer.sv ***
// Power state sequencer for a wireless companion chip
`timescale 1ns/1ps
module pss_power_state_sequencer
(
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  // Pins from host
  input  wire logic                i_regulator_enable_in,
  input  wire logic                i_host_cmd,
  // Firmware status
  input  wire pss_pkg::pss_ctl_t   i_ctl,
  input  wire logic                i_beacon,
  input  wire logic [15:0]         i_sleep_ticks,
  input  wire logic                i_boot_done,
  // Non-volatile trim
  input  wire logic signed [7:0]   i_crystal_osc_trim,
  // State and rails
  output logic [1:0]               o_pwr_state,
  output logic [1:0]               o_sub_state,
  output pss_pkg::pss_rails_t      o_rails,
  output logic                     o_cold_boot,
  output logic                     o_copy_factory_info_record,
  output logic                     o_rf_full_cal,
  output logic                     o_wake_timer,
  output logic signed [7:0]        o_crystal_osc_trim,
  output logic [23:0]              o_rc_cal
);
  import pss_pkg::*;

  // ===================================================================
  // State
  typedef struct packed {
    logic [2:0]        en_sync;
    logic [2:0]        cmd_sync;
    logic              en_q;
    logic              cmd_q;
    pss_seq_t          seq;
    pss_sub_t          sub;
    logic [7:0]        cnt;
    logic              cold;
    logic              booted;
    logic [9:0]        rc_div;
    logic [15:0]       tmr;
    logic [7:0]        cal_ticks;
    logic [23:0]       cal_acc;
    logic [23:0]       cal_val;
    logic signed [7:0] trim;
  } pss_state_t;

  pss_state_t st_ff;
  pss_state_t nxt_st;
  logic       en_lvl;
  logic       cmd_lvl;
  logic       cmd_edge;
  logic       rc_tick;
  logic       step_done;
  logic       sleep_ok;
  logic       wake_req;

  // ===================================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.en_sync  = {st_ff.en_sync[1:0], i_regulator_enable_in};
    nxt_st.cmd_sync = {st_ff.cmd_sync[1:0], i_host_cmd};
    en_lvl  = st_ff.en_q;
    cmd_lvl = st_ff.cmd_q;
    if (st_ff.en_sync[2] == st_ff.en_sync[1])
      nxt_st.en_q = st_ff.en_sync[2];
    if (st_ff.cmd_sync[2] == st_ff.cmd_sync[1])
      nxt_st.cmd_q = st_ff.cmd_sync[2];
    cmd_edge = nxt_st.cmd_q & ~st_ff.cmd_q;

    // Slow oscillator tick divider
    rc_tick = (st_ff.rc_div == 10'h000);
    if (rc_tick)
      nxt_st.rc_div = RC_DIV_INIT;
    else
      nxt_st.rc_div = st_ff.rc_div - 10'h001;
    step_done = (st_ff.cnt == 8'h00);
    if (!step_done)
      nxt_st.cnt = st_ff.cnt - 8'h01;

    // Autonomous sleep and wake decisions
    sleep_ok = st_ff.booted && !i_ctl.host_pending && !cmd_lvl &&
               !i_ctl.tx_req && !i_ctl.rx_req &&
               (!i_ctl.associated || i_ctl.ps_allow);
    wake_req = cmd_edge || cmd_lvl || (st_ff.tmr == 16'h0000);

    case (st_ff.seq)
      ST_OFF:
      begin
        nxt_st.booted = 1'b0;
        if (en_lvl)
        begin
          nxt_st.seq  = ST_REG;
          nxt_st.cold = 1'b1;
          nxt_st.cnt  = T_REG_CYC;
        end
      end
      ST_REG:
        if (step_done)
        begin
          nxt_st.seq = ST_PWR;
          nxt_st.cnt = T_PWR_CYC;
        end
      ST_PWR:
        if (step_done)
        begin
          nxt_st.seq = ST_CRYSTAL;
          nxt_st.cnt = T_CRYSTAL_CYC;
        end
      ST_CRYSTAL:
        if (step_done)
        begin
          nxt_st.seq = ST_PLL;
          nxt_st.cnt = T_PLL_CYC;
        end
      ST_PLL:
        if (step_done)
        begin
          nxt_st.seq = ST_BOOT;
          nxt_st.cnt = T_BOOT_CYC;
        end
      ST_BOOT:
        if (step_done)
        begin
          nxt_st.seq = ST_BB;
          if (st_ff.cold)
            nxt_st.cnt = T_BB_COLD_CYC;
          else
            nxt_st.cnt = T_BB_WARM_CYC;
        end
      ST_BB:
        if (step_done)
        begin
          nxt_st.seq = ST_RF;
          if (st_ff.cold)
            nxt_st.cnt = T_RF_COLD_CYC;
          else
            nxt_st.cnt = T_RF_WARM_CYC;
        end
      ST_RF:
        if (step_done)
        begin
          nxt_st.seq = ST_RUN;
          nxt_st.sub = SUB_IDLE;
        end
      ST_RUN:
      begin
        if (i_boot_done)
          nxt_st.booted = 1'b1;
        if (i_ctl.tx_req)
          nxt_st.sub = SUB_TX;
        else if (i_ctl.rx_req)
          nxt_st.sub = SUB_RX;
        else
          nxt_st.sub = SUB_IDLE;
        if (sleep_ok)
        begin
          nxt_st.seq = ST_SLEEP;
          nxt_st.sub = SUB_IDLE;
          nxt_st.tmr = i_sleep_ticks;
        end
      end
      ST_SLEEP:
      begin
        if (rc_tick && st_ff.tmr != 16'h0000)
          nxt_st.tmr = st_ff.tmr - 16'h0001;
        if (wake_req)
        begin
          nxt_st.seq  = ST_REG;
          nxt_st.cold = 1'b0;
          nxt_st.cnt  = T_REG_CYC;
        end
      end
      default:
        nxt_st.seq = ST_OFF;
    endcase

    // Timer restarts at each beacon received in the run state
    if (i_beacon && st_ff.seq == ST_RUN)
      nxt_st.tmr = i_sleep_ticks;

    // Runtime slow oscillator calibration
    if (st_ff.seq == ST_RUN)
    begin
      nxt_st.cal_acc = st_ff.cal_acc + 24'h00_0001;
      if (rc_tick)
      begin
        if (st_ff.cal_ticks == CAL_TICKS)
        begin
          nxt_st.cal_val   = st_ff.cal_acc;
          nxt_st.cal_acc   = CAL_RESET;
          nxt_st.cal_ticks = 8'h00;
        end
        else
          nxt_st.cal_ticks = st_ff.cal_ticks + 8'h01;
      end
    end

    // Crystal trim clamped to range
    if (i_crystal_osc_trim > TRIM_MAX)
      nxt_st.trim = TRIM_MAX;
    else if (i_crystal_osc_trim < -TRIM_MAX)
      nxt_st.trim = -TRIM_MAX;
    else
      nxt_st.trim = i_crystal_osc_trim;

    // Enable low overrides everything
    if (!en_lvl)
    begin
      nxt_st.seq     = ST_OFF;
      nxt_st.sub     = SUB_IDLE;
      nxt_st.cnt     = 8'h00;
      nxt_st.booted  = 1'b0;
      nxt_st.cal_acc = CAL_RESET;
      nxt_st.cal_val = CAL_RESET;
      nxt_st.tmr     = 16'h0000;
      nxt_st.cal_ticks = 8'h00;
      nxt_st.cold    = 1'b0;
    end
  end

  // ===================================================================
  // Registers
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ===================================================================
  // Outputs
  always_comb
  begin
    o_rails     = '0;
    o_pwr_state = PS_ACTIVE;
    case (st_ff.seq)
      ST_OFF:
      begin
        o_pwr_state = PS_SHUTDOWN;
      end
      ST_SLEEP:
      begin
        o_pwr_state                  = PS_SLEEP;
        o_rails.pulse_skip_low_power = 1'b1;
        o_rails.reg_on               = 1'b1;
        o_rails.retention_on         = 1'b1;
        o_rails.host_if_on           = 1'b1;
        o_rails.rc_osc_on            = 1'b1;
      end
      ST_REG:
      begin
        o_rails.reg_on     = 1'b1;
        o_rails.host_if_on = 1'b1;
        o_rails.rc_osc_on  = 1'b1;
      end
      ST_PWR:
      begin
        o_rails.reg_on       = 1'b1;
        o_rails.host_if_on   = 1'b1;
        o_rails.rc_osc_on    = 1'b1;
        o_rails.analog_on    = 1'b1;
        o_rails.logic_on     = 1'b1;
        o_rails.retention_on = 1'b1;
      end
      ST_CRYSTAL:
      begin
        o_rails.reg_on         = 1'b1;
        o_rails.host_if_on     = 1'b1;
        o_rails.rc_osc_on      = 1'b1;
        o_rails.analog_on      = 1'b1;
        o_rails.logic_on       = 1'b1;
        o_rails.retention_on   = 1'b1;
        o_rails.crystal_osc_on = 1'b1;
      end
      default:
      begin
        o_pwr_state            = PS_ACTIVE;
        o_rails.reg_on         = 1'b1;
        o_rails.host_if_on     = 1'b1;
        o_rails.rc_osc_on      = 1'b1;
        o_rails.analog_on      = 1'b1;
        o_rails.logic_on       = 1'b1;
        o_rails.retention_on   = 1'b1;
        o_rails.crystal_osc_on = 1'b1;
        o_rails.pll_on         = 1'b1;
      end
    endcase
  end

  // ===================================================================
  // Status outputs
  assign o_sub_state                = st_ff.sub;
  assign o_cold_boot                = st_ff.cold;
  assign o_copy_factory_info_record = st_ff.cold && (st_ff.seq == ST_BB);
  assign o_rf_full_cal              = st_ff.cold && (st_ff.seq == ST_RF);
  assign o_wake_timer               = (st_ff.seq == ST_SLEEP);
  assign o_crystal_osc_trim         = st_ff.trim;
  assign o_rc_cal                   = st_ff.cal_val;
endmodule

// *** verification/pss_chk.sv ***
// Port checker of the power state sequencer
`timescale 1ns/1ps
module pss_chk
(
  // Clock, reset, pin
  input wire logic                i_clk,
  input wire logic                i_sys_rst,
  input wire logic                i_regulator_enable_in,
  // State
  input wire logic [1:0]          o_pwr_state,
  input wire logic [1:0]          o_sub_state,
  input wire pss_pkg::pss_rails_t o_rails,
  input wire logic                o_cold_boot,
  input wire logic                o_copy_factory_info_record,
  input wire logic                o_rf_full_cal,
  input wire logic                o_wake_timer,
  input wire logic signed [7:0]   o_crystal_osc_trim
);
  import pss_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_leave_off;
    o_pwr_state == 2'h0 ##1 o_pwr_state != 2'h0;
  endsequence
  property p_legal;
    o_pwr_state != 2'h3 && o_sub_state != 2'h3;
  endproperty
  property p_off;
    o_pwr_state == 2'h0 |-> o_rails == '0;
  endproperty
  property p_sleep;
    o_pwr_state == 2'h1 |-> o_rails.pulse_skip_low_power && o_wake_timer
      && !o_rails.crystal_osc_on && !o_rails.logic_on
      && o_rails.retention_on && o_rails.host_if_on;
  endproperty
  property p_busy;
    o_sub_state != 2'h0 |-> o_rails.crystal_osc_on
      && !o_rails.pulse_skip_low_power;
  endproperty
  property p_en_low;
    !i_regulator_enable_in [*7] |-> o_pwr_state == 2'h0;
  endproperty
  property p_cold_entry;
    s_leave_off |-> o_pwr_state == 2'h2 && o_sub_state == 2'h0
      && o_cold_boot;
  endproperty
  property p_copy;
    o_copy_factory_info_record |-> o_cold_boot && !o_rf_full_cal;
  endproperty
  property p_cal;
    o_rf_full_cal |-> o_cold_boot && o_pwr_state == 2'h2;
  endproperty
  property p_order;
    $fell(o_copy_factory_info_record) && o_pwr_state == 2'h2
      |-> ##[0:1] o_rf_full_cal;
  endproperty
  property p_trim;
    o_crystal_osc_trim <= 8'sh14 && o_crystal_osc_trim >= -8'sh14;
  endproperty
  a_legal: assert property (p_legal) else $error("bad state code");
  a_off: assert property (p_off) else $error("rails on in shutdown");
  a_sleep: assert property (p_sleep) else $error("sleep rails");
  a_busy: assert property (p_busy) else $error("active rails");
  a_en_low: assert property (p_en_low) else $error("no shutdown");
  a_cold_entry: assert property (p_cold_entry) else $error("entry");
  a_copy: assert property (p_copy) else $error("copy on warm");
  a_cal: assert property (p_cal) else $error("full cal on warm");
  a_order: assert property (p_order) else $error("step order");
  a_trim: assert property (p_trim) else $error("trim range");
endmodule
bind pss_power_state_sequencer pss_chk u_pss_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_regulator_enable_in(i_regulator_enable_in),
  .o_pwr_state(o_pwr_state), .o_sub_state(o_sub_state),
  .o_rails(o_rails), .o_cold_boot(o_cold_boot),
  .o_copy_factory_info_record(o_copy_factory_info_record),
  .o_rf_full_cal(o_rf_full_cal), .o_wake_timer(o_wake_timer),
  .o_crystal_osc_trim(o_crystal_osc_trim));

// *** verification/pss_host_model.sv ***
// Host model driving the enable pin and command activity
`timescale 1ns/1ps
module pss_host_model
(
  // Clock and requests
  input  wire logic i_clk,
  input  wire logic i_en_req,
  input  wire logic i_cmd_req,
  // Pins
  output logic      o_en,
  output logic      o_cmd
);
  logic [2:0] hold;
  initial
  begin
    o_en  = 1'b0;
    o_cmd = 1'b0;
    hold  = 3'h0;
  end
  // Command stretched over four cycles
  always @(negedge i_clk)
  begin
    o_en  <= i_en_req;
    hold  <= i_cmd_req ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : hold);
    o_cmd <= i_cmd_req || hold > 3'h1;
  end
endmodule

// *** verification/test_power_state_sequencer.sv ***
// Testbench of the power state sequencer
`timescale 1ns/1ps
module test_power_state_sequencer;
  import pss_pkg::*;
  logic              clk, rst, en_req, cmd_req, en, cmd, beacon, boot;
  pss_ctl_t          ctl;
  logic [15:0]       ticks;
  logic signed [7:0] trim, otrim;
  logic [1:0]        pwr, sub;
  pss_rails_t        rails;
  logic              cold, copy, rfcal, wtmr;
  logic [23:0]       rccal;
  int                n_mismatch, n_checks;
  pss_host_model u_pss_host_model (.i_clk(clk), .i_en_req(en_req),
    .i_cmd_req(cmd_req), .o_en(en), .o_cmd(cmd));
  pss_power_state_sequencer u_pss_power_state_sequencer (.i_clk(clk),
    .i_sys_rst(rst), .i_regulator_enable_in(en), .i_host_cmd(cmd),
    .i_ctl(ctl), .i_beacon(beacon), .i_sleep_ticks(ticks),
    .i_boot_done(boot), .i_crystal_osc_trim(trim), .o_pwr_state(pwr),
    .o_sub_state(sub), .o_rails(rails), .o_cold_boot(cold),
    .o_copy_factory_info_record(copy), .o_rf_full_cal(rfcal),
    .o_wake_timer(wtmr), .o_crystal_osc_trim(otrim), .o_rc_cal(rccal));
  always #20 clk = ~clk;
  task automatic chk(input string nm, input logic [23:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input logic [1:0] s, input int lim);
    for (int i = 0; i < lim && pwr !== s; i++)
      @(negedge clk);
  endtask
  task automatic run(input int n, output int nc, output int nr);
    nc = 0;
    nr = 0;
    repeat (n)
    begin
      @(negedge clk);
      nc += int'(copy === 1'b1);
      nr += int'(rfcal === 1'b1);
    end
  endtask
  task host_cmd;
    cmd_req <= 1'b1;
    @(negedge clk);
    cmd_req <= 1'b0;
  endtask
  task t_ignore;
    boot = 1'b1;
    host_cmd();
    repeat (20) @(negedge clk);
    boot = 1'b0;
    chk("pwr", 24'h0, 24'(pwr));
  endtask
  task t_cold;
    int nc, nr;
    en_req <= 1'b1;
    wt(2'h2, 20);
    chk("sub", 24'h0, 24'(sub));
    chk("cold", 24'h1, 24'(cold));
    run(400, nc, nr);
    chk("copy", 24'h41, 24'(nc));
    chk("rfcal", 24'h81, 24'(nr));
    chk("pwr", 24'h2, 24'(pwr));
    boot = 1'b1;
    wt(2'h1, 20);
    chk("crystal", 24'h0, 24'(rails.crystal_osc_on));
    chk("wtmr", 24'h1, 24'(wtmr));
  endtask
  task t_warm;
    int nc, nr;
    host_cmd();
    wt(2'h2, 20);
    chk("cold", 24'h0, 24'(cold));
    run(200, nc, nr);
    chk("copy", 24'h0, 24'(nc));
    chk("rfcal", 24'h0, 24'(nr));
    chk("pwr", 24'h1, 24'(pwr));
  endtask
  task automatic t_hold;
    int nc, nr, n;
    logic [7:0] ti [3] = '{8'h32, 8'hce, 8'h07};
    logic [7:0] to [3] = '{8'h14, 8'hec, 8'h07};
    ctl.host_pending = 1'b1;
    host_cmd();
    run(200, nc, nr);
    chk("pwr", 24'h2, 24'(pwr));
    ctl.tx_req = 1'b1;
    repeat (4) @(negedge clk);
    chk("sub", 24'h1, 24'(sub));
    ctl.tx_req = 1'b0;
    ctl.rx_req = 1'b1;
    repeat (4) @(negedge clk);
    chk("sub", 24'h2, 24'(sub));
    ctl.rx_req = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      trim = ti[i];
      repeat (3) @(negedge clk);
      chk("trim", 24'(to[i]), 24'(unsigned'(otrim)));
    end
    for (n = 0; n < 30000 && rccal !== 24'(RC_DIV*(int'(CAL_TICKS)+1)-1); n++)
      @(negedge clk);
    chk("rccal", 24'(RC_DIV * (int'(CAL_TICKS) + 1) - 1), rccal);
    ctl.host_pending = 1'b0;
    ctl.associated = 1'b1;
    repeat (20) @(negedge clk);
    chk("pwr", 24'h2, 24'(pwr));
    ctl.ps_allow = 1'b1;
    wt(2'h1, 20);
    chk("pwr", 24'h1, 24'(pwr));
  endtask
  task t_timer;
    int n;
    ticks = 16'h0002;
    beacon = 1'b1;
    host_cmd();
    wt(2'h2, 20);
    wt(2'h1, 300);
    beacon = 1'b0;
    for (n = 0; n < 3000 && pwr === 2'h1; n++)
      @(negedge clk);
    chk("wake", 24'h2, 24'(pwr));
    chk("span", 24'h1, 24'(n > RC_DIV && n <= 2 * RC_DIV + 2));
    ticks = 16'hffff;
  endtask
  task t_off;
    en_req <= 1'b0;
    repeat (8) @(negedge clk);
    chk("pwr", 24'h0, 24'(pwr));
    chk("rails", 24'h0, 24'(rails));
  endtask
  task final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {clk, en_req, cmd_req, beacon, boot, n_mismatch, n_checks} = '0;
    rst = 1'b1;
    ctl = '0;
    ticks = 16'hffff;
    trim = 8'sh00;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk("pwr", 24'h0, 24'(pwr));
    t_ignore();
    t_cold();
    t_warm();
    t_hold();
    t_timer();
    t_off();
    final_report();
  end
  initial
  begin
    #3000000;
    n_mismatch++;
    final_report();
  end
endmodule
